// file: hdl/frac_accum.sv
// Fractional microsteps-per-revolution accumulator
`timescale 1ns/1ps
module frac_accum (
	input  wire logic core_clk,
	input  wire logic arst_n,
	frac_if.accum     fr
);
	logic [31:0] acc_r;
	logic [32:0] sum;

	// One whole microstep at one integer bit and 31 fraction bits
	localparam logic [32:0] WHOLE_STEP = 33'h0_8000_0000;

	// Carry is seen before the add so the caller can hold in the same step
	// A fraction above one can leave a second whole step to drain on the held pass
	assign sum      = {1'b0, acc_r} + {1'b0, fr.fraction};
	assign fr.carry = sum >= WHOLE_STEP;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_r <= pos_wrap_pkg::RST_WORD;
		end else if (fr.add) begin
			acc_r <= fr.carry ? 32'(sum - WHOLE_STEP) : sum[31:0];
		end
	end
endmodule

// file: hdl/frac_if.sv
// Link between the motion logic and the revolution fraction accumulator
`timescale 1ns/1ps
interface frac_if;
	logic        add;
	logic [31:0] fraction;
	logic        carry;

	modport accum (input add, input fraction, output carry);
	modport user  (output add, output fraction, input carry);
endinterface

// file: hdl/pos_wrap_pkg.sv
// Shared constants for the repetitive and circular position block
package pos_wrap_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PERIOD_W = 16;

	localparam logic [7:0] OFS_TARGET_POSITION    = 8'h00;
	localparam logic [7:0] OFS_SWITCH_COMPARE_CFG = 8'h01;
	localparam logic [7:0] OFS_RAMP_SELECTION     = 8'h20;
	localparam logic [7:0] OFS_ACTUAL_POSITION    = 8'h21;
	localparam logic [7:0] OFS_MOTION_STATUS      = 8'h22;
	localparam logic [7:0] OFS_REVOLUTION_COUNT   = 8'h23;
	localparam logic [7:0] OFS_STEP_PERIOD        = 8'h24;
	localparam logic [7:0] OFS_WRAP_RANGE_LIMIT   = 8'h36;
	localparam logic [7:0] OFS_REVOLUTION_FRACT   = 8'h7C;

	localparam int unsigned CFG_ZERO_ON_ARRIVAL = 0;
	localparam int unsigned CFG_WRAP_ENABLE     = 1;
	localparam int unsigned CFG_VELOCITY_RUN    = 2;
	localparam int unsigned CFG_VELOCITY_NEG    = 3;
	localparam int unsigned CFG_USED_W          = 4;

	localparam int unsigned RAMP_SEL_W     = 3;
	localparam int unsigned RAMP_POSITION  = 2;

	localparam int unsigned STAT_REACHED = 0;
	localparam int unsigned STAT_MOVING  = 1;
	localparam int unsigned STAT_DIR_FWD = 2;
	localparam int unsigned STAT_HOLD    = 3;

	localparam logic [31:0]         RST_WORD         = 32'h0000_0000;
	localparam logic [PERIOD_W-1:0] RST_STEP_PERIOD  = 16'h0064;
	localparam logic [31:0]         ONE_STEP         = 32'h0000_0001;
endpackage

// file: hdl/repetitive_circular_position_wrap.sv
// Repetitive positioning and circular position wrap for a step generator
`timescale 1ns/1ps
module repetitive_circular_position_wrap (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata_r,
	output logic             step_pulse_r,
	output logic             step_dir_fwd_r,
	output logic             target_reached_r
);
	logic [31:0]                         cfg_r;
	logic [pos_wrap_pkg::RAMP_SEL_W-1:0] ramp_sel_r;
	logic [31:0]                         target_r;
	logic [31:0]                         actual_r;
	logic [31:0]                         actual_nxt;
	logic [31:0]                         range_r;
	logic [31:0]                         frac_r;
	logic [31:0]                         rev_cnt_r;
	logic [pos_wrap_pkg::PERIOD_W-1:0]   period_r;
	logic                                hold_r;
	logic                                tick;
	logic                                wrap_en;
	logic                                pos_mode;
	logic                                arrived;
	logic                                arrival_clear;
	logic                                want_move;
	logic                                move_fwd;
	logic                                at_top;
	logic                                at_bot;
	logic                                crossing;
	logic                                hold_set;
	logic                                in_range;
	logic signed [32:0]                  diff;
	logic                                wr_cfg;
	logic                                wr_actual;

	frac_if fr ();

	// Shorter way round a circle of twice the range
	function automatic logic path_forward(input logic signed [32:0] d, input logic [31:0] r);
		logic [32:0] mag;
		mag = d[32] ? 33'(-d) : 33'(d);
		return (!d[32] && d != '0) ^ (mag > {1'b0, r});
	endfunction

	function automatic logic wr_hit(input logic [7:0] ofs);
		return reg_wr && reg_addr == ofs;
	endfunction

	step_rate_div #(
		.W (pos_wrap_pkg::PERIOD_W)
	) u_div (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.period   (period_r),
		.tick_r   (tick)
	);

	frac_accum u_acc (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.fr       (fr.accum)
	);

	assign wr_cfg    = wr_hit(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG);
	assign wr_actual = wr_hit(pos_wrap_pkg::OFS_ACTUAL_POSITION);

	// A zero range leaves wrap off even with the enable bit set
	assign wrap_en  = cfg_r[pos_wrap_pkg::CFG_WRAP_ENABLE] && range_r != '0;
	assign pos_mode = ramp_sel_r[pos_wrap_pkg::RAMP_POSITION];
	assign arrived  = actual_r == target_r;
	assign arrival_clear = pos_mode && arrived && cfg_r[pos_wrap_pkg::CFG_ZERO_ON_ARRIVAL];
	assign diff     = $signed({target_r[31], target_r}) - $signed({actual_r[31], actual_r});
	assign in_range = $signed(actual_r) >= -$signed(range_r) && $signed(actual_r) < $signed(range_r);

	always_comb begin
		if (pos_mode) begin
			want_move = !arrived;
			move_fwd  = wrap_en ? path_forward(diff, range_r) : !diff[32];
		end else begin
			want_move = cfg_r[pos_wrap_pkg::CFG_VELOCITY_RUN];
			move_fwd  = !cfg_r[pos_wrap_pkg::CFG_VELOCITY_NEG];
		end
	end

	assign at_top   = wrap_en && actual_r == range_r - pos_wrap_pkg::ONE_STEP;
	assign at_bot   = wrap_en && actual_r == 32'(-range_r);
	assign crossing = tick && want_move && ((move_fwd && at_top) || (!move_fwd && at_bot));
	// Held passes add nothing, they only drain whole steps still owed
	assign fr.add      = crossing;
	assign fr.fraction = hold_r ? pos_wrap_pkg::RST_WORD : frac_r;
	assign hold_set    = fr.add && fr.carry;

	always_comb begin
		actual_nxt = actual_r;
		if (arrival_clear) begin
			actual_nxt = pos_wrap_pkg::RST_WORD;
		end else if (tick && want_move) begin
			if (crossing) begin
				if (!hold_set) begin
					actual_nxt = move_fwd ? 32'(-range_r) : range_r - pos_wrap_pkg::ONE_STEP;
				end
			end else begin
				actual_nxt = move_fwd ? actual_r + pos_wrap_pkg::ONE_STEP : actual_r - pos_wrap_pkg::ONE_STEP;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			actual_r <= pos_wrap_pkg::RST_WORD;
		end else if (wr_actual) begin
			actual_r <= reg_wdata;
		end else begin
			actual_r <= actual_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_r <= 1'b0;
		end else if (!wrap_en || wr_actual) begin
			hold_r <= 1'b0;
		end else if (hold_set) begin
			hold_r <= 1'b1;
		end else if (crossing) begin
			hold_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rev_cnt_r <= pos_wrap_pkg::RST_WORD;
		end else if (!wrap_en) begin
			rev_cnt_r <= pos_wrap_pkg::RST_WORD;
		end else if (crossing && !hold_set && !wr_actual) begin
			rev_cnt_r <= move_fwd ? rev_cnt_r + pos_wrap_pkg::ONE_STEP : rev_cnt_r - pos_wrap_pkg::ONE_STEP;
		end
	end

	// A held step still goes out to the driver
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			step_pulse_r     <= 1'b0;
			step_dir_fwd_r   <= 1'b1;
			target_reached_r <= 1'b0;
		end else begin
			step_pulse_r     <= tick && want_move && !arrival_clear && !wr_actual;
			target_reached_r <= arrived;
			if (tick && want_move) begin
				step_dir_fwd_r <= move_fwd;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_r      <= pos_wrap_pkg::RST_WORD;
			ramp_sel_r <= '0;
			target_r   <= pos_wrap_pkg::RST_WORD;
			range_r    <= pos_wrap_pkg::RST_WORD;
			frac_r     <= pos_wrap_pkg::RST_WORD;
			period_r   <= pos_wrap_pkg::RST_STEP_PERIOD;
		end else if (reg_wr) begin
			case (reg_addr)
				pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG: cfg_r <= {28'h0, reg_wdata[pos_wrap_pkg::CFG_USED_W-1:0]};
				pos_wrap_pkg::OFS_RAMP_SELECTION:     ramp_sel_r <= reg_wdata[pos_wrap_pkg::RAMP_SEL_W-1:0];
				pos_wrap_pkg::OFS_TARGET_POSITION:    target_r <= reg_wdata;
				pos_wrap_pkg::OFS_WRAP_RANGE_LIMIT:   range_r <= reg_wdata;
				pos_wrap_pkg::OFS_REVOLUTION_FRACT:   frac_r <= reg_wdata;
				pos_wrap_pkg::OFS_STEP_PERIOD:        period_r <= reg_wdata[pos_wrap_pkg::PERIOD_W-1:0];
				default: ;
			endcase
		end
	end

	// Range is write-only and reads back as zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_r <= pos_wrap_pkg::RST_WORD;
		end else if (reg_rd) begin
			case (reg_addr)
				pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG: reg_rdata_r <= cfg_r;
				pos_wrap_pkg::OFS_RAMP_SELECTION:     reg_rdata_r <= {29'h0, ramp_sel_r};
				pos_wrap_pkg::OFS_TARGET_POSITION:    reg_rdata_r <= target_r;
				pos_wrap_pkg::OFS_ACTUAL_POSITION:    reg_rdata_r <= actual_r;
				pos_wrap_pkg::OFS_REVOLUTION_COUNT:   reg_rdata_r <= rev_cnt_r;
				pos_wrap_pkg::OFS_REVOLUTION_FRACT:   reg_rdata_r <= frac_r;
				pos_wrap_pkg::OFS_STEP_PERIOD:        reg_rdata_r <= {16'h0, period_r};
				pos_wrap_pkg::OFS_MOTION_STATUS:      reg_rdata_r <= {28'h0, hold_r, step_dir_fwd_r, want_move, arrived};
				default:                              reg_rdata_r <= pos_wrap_pkg::RST_WORD;
			endcase
		end else begin
			reg_rdata_r <= pos_wrap_pkg::RST_WORD;
		end
	end

	chk_stop_at_target: assert property (@(posedge core_clk) disable iff (!arst_n)
		pos_mode && arrived && !cfg_r[pos_wrap_pkg::CFG_ZERO_ON_ARRIVAL] |=> !step_pulse_r)
		else $error("step issued while parked at target");

	chk_zero_on_arrival: assert property (@(posedge core_clk) disable iff (!arst_n)
		arrival_clear && !wr_actual |=> actual_r == pos_wrap_pkg::RST_WORD)
		else $error("actual position not cleared on arrival");

	chk_repeat_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
		arrival_clear && !wr_actual && target_r != '0 && !reg_wr |=> want_move)
		else $error("ramp did not restart after clear");

	chk_range_kept: assert property (@(posedge core_clk) disable iff (!arst_n)
		wrap_en && in_range && !reg_wr |=> in_range)
		else $error("actual position left the wrap range");

	chk_wrap_upward: assert property (@(posedge core_clk) disable iff (!arst_n)
		crossing && move_fwd && !hold_set && !wr_actual |=> actual_r == 32'(-range_r))
		else $error("upward wrap target wrong");

	chk_wrap_downward: assert property (@(posedge core_clk) disable iff (!arst_n)
		crossing && !move_fwd && !hold_set && !wr_actual |=> actual_r == range_r - pos_wrap_pkg::ONE_STEP)
		else $error("downward wrap target wrong");

	chk_hold_one_step: assert property (@(posedge core_clk) disable iff (!arst_n)
		hold_set && !wr_actual && !wr_cfg |=> hold_r && actual_r == $past(actual_r) && fr.fraction == pos_wrap_pkg::RST_WORD)
		else $error("overflow hold not taken");

	chk_rev_count_up: assert property (@(posedge core_clk) disable iff (!arst_n)
		crossing && move_fwd && !hold_set && !wr_actual && !wr_cfg |=> rev_cnt_r == $past(rev_cnt_r) + 32'h1)
		else $error("revolution counter not incremented");

	chk_rev_cleared: assert property (@(posedge core_clk) disable iff (!arst_n)
		!wrap_en |=> rev_cnt_r == pos_wrap_pkg::RST_WORD)
		else $error("revolution counter not cleared");

	chk_no_wrap_off: assert property (@(posedge core_clk) disable iff (!arst_n)
		!wrap_en |-> !fr.add && !crossing)
		else $error("wrap activity with wrap disabled");

	chk_no_idle_step: assert property (@(posedge core_clk) disable iff (!arst_n)
		!(tick && want_move)
		|=> !step_pulse_r)
		else $error("step issued without a rate tick");

	chk_step_on_tick: assert property (@(posedge core_clk) disable iff (!arst_n)
		tick && want_move && !arrival_clear && !wr_actual
		|=> step_pulse_r)
		else $error("wanted step not issued");

	chk_dir_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
		tick && want_move
		|=> step_dir_fwd_r == $past(move_fwd))
		else $error("step direction does not follow the chosen way");

	chk_reached_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
		!arrived
		|=> !target_reached_r)
		else $error("target flag set away from target");

	chk_clear_no_step: assert property (@(posedge core_clk) disable iff (!arst_n)
		arrival_clear
		|=> !step_pulse_r)
		else $error("step issued on the arrival clear");

	chk_free_up: assert property (@(posedge core_clk) disable iff (!arst_n)
		!wrap_en && tick && want_move && move_fwd && !arrival_clear && !wr_actual
		|=> actual_r == $past(actual_r) + pos_wrap_pkg::ONE_STEP)
		else $error("unlimited forward step wrong");

	chk_free_down: assert property (@(posedge core_clk) disable iff (!arst_n)
		!wrap_en && tick && want_move && !move_fwd && !arrival_clear && !wr_actual
		|=> actual_r == $past(actual_r) - pos_wrap_pkg::ONE_STEP)
		else $error("unlimited backward step wrong");

	chk_rev_count_down: assert property (@(posedge core_clk) disable iff (!arst_n)
		crossing && !move_fwd && !hold_set && !reg_wr
		|=> rev_cnt_r == $past(rev_cnt_r) - pos_wrap_pkg::ONE_STEP)
		else $error("revolution counter not decremented");

	chk_hold_no_count: assert property (@(posedge core_clk) disable iff (!arst_n)
		hold_set && !reg_wr
		|=> rev_cnt_r == $past(rev_cnt_r))
		else $error("revolution counted on a held step");

	chk_hold_pulses: assert property (@(posedge core_clk) disable iff (!arst_n)
		hold_set && !wr_actual
		|=> step_pulse_r)
		else $error("held step not sent to the driver");

	chk_whole_frac_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
		crossing && !hold_r && frac_r[$bits(frac_r)-1]
		|-> hold_set)
		else $error("fraction of one did not hold the revolution");

	chk_target_write: assert property (@(posedge core_clk) disable iff (!arst_n)
		reg_wr && reg_addr == pos_wrap_pkg::OFS_TARGET_POSITION
		|=> target_r == $past(reg_wdata))
		else $error("target change not taken");

	chk_frac_write: assert property (@(posedge core_clk) disable iff (!arst_n)
		reg_wr && reg_addr == pos_wrap_pkg::OFS_REVOLUTION_FRACT
		|=> frac_r == $past(reg_wdata))
		else $error("revolution fraction not taken");

	chk_short_direct: assert property (@(posedge core_clk) disable iff (!arst_n)
		pos_mode && wrap_en && want_move && diff < $signed({1'b0, range_r}) && diff > -$signed({1'b0, range_r})
		|-> move_fwd == !diff[32])
		else $error("direct way not taken");

	chk_short_across: assert property (@(posedge core_clk) disable iff (!arst_n)
		pos_mode && wrap_en && want_move && (diff > $signed({1'b0, range_r}) || diff < -$signed({1'b0, range_r}))
		|-> move_fwd == diff[32])
		else $error("way across the wrap point not taken");
endmodule

// file: hdl/step_rate_div.sv
// Step rate divider producing a one-cycle step enable
`timescale 1ns/1ps
module step_rate_div #(
	parameter int unsigned W = pos_wrap_pkg::PERIOD_W
) (
	input  wire logic         core_clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] period,
	output logic              tick_r
);
	logic [W-1:0] cnt_r;

	// Period zero stops stepping altogether
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else if (period == '0 || cnt_r >= period - W'(1)) begin
			cnt_r  <= '0;
			tick_r <= (period != '0);
		end else begin
			cnt_r  <= cnt_r + W'(1);
			tick_r <= 1'b0;
		end
	end
endmodule

// file: verif/repetitive_circular_position_wrap_tb.sv
// Self-checking bench for the repetitive and circular position block
`timescale 1ns/1ps
module repetitive_circular_position_wrap_tb;
	logic        core_clk  = 1'b0;
	logic        arst_n    = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata_r;
	logic        step_pulse_r;
	logic        step_dir_fwd_r;
	logic        target_reached_r;
	int          step_cnt;
	int          net_pos;
	int          errors    = 0;
	int          cmp_count = 0;
	int          c0;
	int          p0;
	logic [31:0] acc       = 32'h0000_0000;
	logic [31:0] fracs [4] = '{32'h8000_0000, 32'h4000_0000, 32'hA000_0000, 32'h0000_0000};

	always #5 core_clk = ~core_clk;

	repetitive_circular_position_wrap i_repetitive_circular_position_wrap (
		.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .step_pulse_r(step_pulse_r),
		.step_dir_fwd_r(step_dir_fwd_r), .target_reached_r(target_reached_r));

	step_driver_model i_step_driver_model (
		.core_clk(core_clk), .arst_n(arst_n), .step_pulse_r(step_pulse_r),
		.step_dir_fwd_r(step_dir_fwd_r), .step_cnt(step_cnt), .net_pos(net_pos));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata_r, exp);
	endtask

	task automatic wait_arrive();
		int n;
		n = 0;
		repeat (3) @(posedge core_clk);
		#1;
		while (target_reached_r !== 1'b1 && n < 500) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(32'(n < 500), 32'h1);
		repeat (3) @(posedge core_clk);
	endtask

	// Forward steps from zero with range 4; accumulator persists across runs
	task automatic sim_fwd(input int n, input logic [31:0] f, output int pos, output int rev);
		logic        hold;
		logic [32:0] s;
		pos  = 0;
		rev  = 0;
		hold = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (pos != 3) begin
				pos++;
			end else begin
				// Held pass adds nothing, only drains whole steps still owed
				s = {1'b0, acc} + (hold ? 33'h0_0000_0000 : {1'b0, f});
				if (s >= 33'h0_8000_0000) begin
					acc  = 32'(s - 33'h0_8000_0000);
					hold = 1'b1;
				end else begin
					acc  = s[31:0];
					pos  = -4;
					rev++;
					hold = 1'b0;
				end
			end
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		final_report();
	end

	initial begin
		int pos;
		int rev;
		int n;
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		chk({31'h0, step_dir_fwd_r}, 32'h1);
		rd(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG, 32'h0);
		rd(pos_wrap_pkg::OFS_REVOLUTION_FRACT, 32'h0);
		wr(pos_wrap_pkg::OFS_WRAP_RANGE_LIMIT, 32'h4);
		rd(pos_wrap_pkg::OFS_WRAP_RANGE_LIMIT, 32'h0);
		rd(8'h55, 32'h0);
		wr(pos_wrap_pkg::OFS_STEP_PERIOD, 32'h1);
		wr(pos_wrap_pkg::OFS_RAMP_SELECTION, 32'h4);
		wr(pos_wrap_pkg::OFS_TARGET_POSITION, 32'h5);
		wait_arrive();
		rd(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'h5);
		rd(pos_wrap_pkg::OFS_MOTION_STATUS, 32'h5);
		c0 = step_cnt;
		repeat (20) @(posedge core_clk);
		chk(32'(step_cnt - c0), 32'h0);
		// Repetition, then a negative target mid-run
		wr(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'h0);
		wr(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG, 32'h1);
		wr(pos_wrap_pkg::OFS_TARGET_POSITION, 32'h3);
		repeat (60) @(posedge core_clk);
		chk(32'(step_cnt - c0 > 12), 32'h1);
		p0 = net_pos;
		wr(pos_wrap_pkg::OFS_TARGET_POSITION, 32'hFFFF_FFFE);
		repeat (60) @(posedge core_clk);
		chk(32'(net_pos - p0 < -8), 32'h1);
		wr(pos_wrap_pkg::OFS_TARGET_POSITION, 32'h0);
		wait_arrive();
		c0 = step_cnt;
		repeat (20) @(posedge core_clk);
		rd(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'h0);
		chk(32'(step_cnt - c0), 32'h0);
		// Circular positioning both ways across the wrap point
		wr(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG, 32'h0);
		wr(pos_wrap_pkg::OFS_TARGET_POSITION, 32'h2);
		wr(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'h2);
		wr(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG, 32'h2);
		p0 = net_pos;
		wr(pos_wrap_pkg::OFS_TARGET_POSITION, 32'hFFFF_FFFD);
		wait_arrive();
		rd(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'hFFFF_FFFD);
		rd(pos_wrap_pkg::OFS_REVOLUTION_COUNT, 32'h1);
		chk(32'(net_pos - p0), 32'h3);
		p0 = net_pos;
		wr(pos_wrap_pkg::OFS_TARGET_POSITION, 32'h2);
		wait_arrive();
		rd(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'h2);
		rd(pos_wrap_pkg::OFS_REVOLUTION_COUNT, 32'h0);
		chk(32'(net_pos - p0), 32'hFFFF_FFFD);
		// Free running forward with each fraction
		wr(pos_wrap_pkg::OFS_RAMP_SELECTION, 32'h0);
		foreach (fracs[k]) begin
			wr(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG, 32'h0);
			wr(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'h0);
			wr(pos_wrap_pkg::OFS_REVOLUTION_FRACT, fracs[k]);
			rd(pos_wrap_pkg::OFS_REVOLUTION_FRACT, fracs[k]);
			c0 = step_cnt;
			n  = 0;
			wr(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG, 32'h6);
			while (step_cnt - c0 < 40 && n < 500) begin
				@(posedge core_clk);
				n++;
			end
			wr(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG, 32'h2);
			repeat (4) @(posedge core_clk);
			sim_fwd(step_cnt - c0, fracs[k], pos, rev);
			rd(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'(pos));
			rd(pos_wrap_pkg::OFS_REVOLUTION_COUNT, 32'(rev));
		end
		wr(pos_wrap_pkg::OFS_SWITCH_COMPARE_CFG, 32'h0);
		rd(pos_wrap_pkg::OFS_REVOLUTION_COUNT, 32'h0);
		wr(pos_wrap_pkg::OFS_RAMP_SELECTION, 32'h4);
		wr(pos_wrap_pkg::OFS_TARGET_POSITION, 32'hA);
		wait_arrive();
		rd(pos_wrap_pkg::OFS_ACTUAL_POSITION, 32'hA);
		final_report();
	end
endmodule

// file: verif/step_driver_model.sv
// Behavioural stepper driver that counts step commands
`timescale 1ns/1ps
module step_driver_model (
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic step_pulse_r,
	input  wire logic step_dir_fwd_r,
	output int        step_cnt,
	output int        net_pos
);
	// Direction sampled with the pulse, as a real driver latches it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			step_cnt <= 0;
			net_pos  <= 0;
		end else if (step_pulse_r === 1'b1) begin
			step_cnt <= step_cnt + 1;
			net_pos  <= (step_dir_fwd_r === 1'b1) ? net_pos + 1 : net_pos - 1;
		end
	end
endmodule
